// File: core/bidir_shift8.sv
// eight-stage left/right shift register with hold
// assumes a free-running clock and same-domain controls
`timescale 1ns/1ps
module bidir_shift8 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // direction control
  input wire shift_seq_pkg::dir_e dir,
  // serial entry
  input wire logic ser_right_in,
  input wire logic ser_left_in,
  // stage outputs, first stage in the msb
  output logic [WIDTH-1:0] q
);
  import shift_seq_pkg::*;

  // ==========================================
  // elaboration check
  initial begin
    if (WIDTH < 2) begin
      $error("bidir_shift8 needs at least two stages");
    end
  end

  // ==========================================
  // stages, falling-edge triggered
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      unique case (dir)
        DIR_RIGHT: begin
          q <= {ser_right_in, q[WIDTH-1:1]};
        end
        DIR_LEFT: begin
          q <= {q[WIDTH-2:0], ser_left_in};
        end
        DIR_HOLD, DIR_RSVD: begin
          q <= q; // code 11 is unused, held safe
        end
      endcase
    end
  end

endmodule

// File: core/shift_register_sequencer.sv
// shift register sequencer top: four-stage register with ring,
// twisted ring and modulo-n sequencers, plus an eight-stage
// left/right register, configured over an apb slave.
// assumes all pin inputs come from logic on clk, so no
// synchroniser is placed on them.
`timescale 1ns/1ps
`include "shift_seq_consts.svh"
module shift_register_sequencer #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // four-stage register pins
  input wire logic ctl_load,
  input wire logic ctl_shift,
  input wire logic ser_in,
  input wire logic [3:0] par_in,
  // eight-stage register pins
  input wire shift_seq_pkg::dir_e dir_ctl,
  input wire logic ser_right_in,
  input wire logic ser_left_in,
  // stage outputs
  output logic [3:0] q4,
  output logic [7:0] q8,
  output logic period_end
);
  import shift_seq_pkg::*;

  // ==========================================
  // elaboration check
  initial begin
    // the offset decode reads the low address byte
    if (ADDR_W < 8) begin
      $error("address too narrow for the register map");
    end
  end

  // ==========================================
  // helper functions

  // end-of-period detection, used by control and status
  function automatic logic is_end(input logic [3:0] s);
    is_end = (s == `END_WORD);
  endfunction

  // all-ones lock-up state of the modulo recurrence
  function automatic logic is_ones(input logic [3:0] s);
    is_ones = (s == `ALL_ONES);
  endfunction

  // register offset match on the low address byte
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[7:0] == ofs);
  endfunction

  // ==========================================
  // configuration registers
  mode_e mode_q;
  logic tap_q;
  logic lock_q;
  logic [3:0] mod_start_q;

  // ==========================================
  // apb handshake state
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access;
  logic mapped;
  logic [31:0] rdata_d;

  // ==========================================
  // sequencer wiring
  logic seq_load;
  logic seq_shift;
  logic seq_ser;
  logic [3:0] seq_par;
  logic [3:0] q4_w;
  logic [7:0] q8_w;
  logic end_q;
  logic a_s;
  logic b_s;
  logic c_s;
  logic d_s;
  logic mod_fb;
  logic ring_zero;

  // access phase still waiting for its answer
  assign access = psel && penable && !pready_q;

  // decode of the three mapped words
  assign mapped = hit(paddr, `OFS_CTRL) || hit(paddr, `OFS_MOD_START) || hit(paddr, `OFS_STATUS);

  // ==========================================
  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(paddr, `OFS_CTRL)) begin
      rdata_d[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = mode_q;
      rdata_d[`CTRL_TAP_BIT] = tap_q;
      rdata_d[`CTRL_LOCK_BIT] = lock_q;
    end else if (hit(paddr, `OFS_MOD_START)) begin
      rdata_d[3:0] = mod_start_q;
    end else if (hit(paddr, `OFS_STATUS)) begin
      rdata_d[`STAT_Q4_LSB +: 4] = q4_w;
      rdata_d[`STAT_Q8_LSB +: 8] = q8_w;
      rdata_d[`STAT_END_BIT] = end_q;
    end
  end

  // ==========================================
  // apb answer: one wait state, so pready and the read
  // data both leave flip-flops as the top outputs demand
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      if (access && !pwrite) begin
        prdata_q <= mapped ? rdata_d : 32'h0000_0000;
      end
    end
  end

  // ==========================================
  // register writes, only at the completing edge;
  // the status word is read-only and ignores writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= mode_e'(`RST_MODE);
      tap_q <= 1'b0;
      lock_q <= 1'b0;
      mod_start_q <= `RST_MOD_START;
    end else if (ce && psel && penable && pready_q && pwrite) begin
      if (hit(paddr, `OFS_CTRL)) begin
        mode_q <= mode_e'(pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
        tap_q <= pwdata[`CTRL_TAP_BIT];
        lock_q <= pwdata[`CTRL_LOCK_BIT];
      end else if (hit(paddr, `OFS_MOD_START)) begin
        mod_start_q <= pwdata[3:0];
      end
    end
  end

  // ==========================================
  // named stages, a is the first stage
  assign a_s = q4_w[3];
  assign b_s = q4_w[2];
  assign c_s = q4_w[1];
  assign d_s = q4_w[0];

  assign ring_zero = !(a_s || b_s || c_s);

  assign mod_fb = tap_q ? !(a_s ^ d_s) : !(c_s ^ d_s);

  // ==========================================
  // control and data steering for the four stages;
  // the start word is a config register, so the outside
  // must leave it alone while a preload may happen
  always_comb begin
    seq_load = 1'b0;
    seq_shift = 1'b0;
    seq_ser = 1'b0;
    seq_par = 4'h0;
    unique case (mode_q)
      MODE_RING: begin
        seq_shift = !ring_zero;
        seq_load = ring_zero;
        // zeros enter, so any stray ones drain out within three shifts
        seq_ser = 1'b0;
        seq_par = `RING_WORD;
      end
      MODE_TWIST: begin
        // gate with a or not c escapes unused loop
        seq_shift = 1'b1;
        seq_ser = !d_s && (a_s || !c_s);
      end
      MODE_MODN: begin
        seq_ser = mod_fb;
        seq_par = mod_start_q;
        if (is_ones(q4_w)) begin
          seq_load = 1'b1;
        end else if (is_end(q4_w) && lock_q) begin
          seq_load = 1'b0;
        end else if (is_end(q4_w)) begin
          seq_load = 1'b1;
        end else begin
          seq_shift = 1'b1;
        end
      end
      default: begin
        seq_load = ctl_load;
        seq_shift = ctl_shift;
        seq_ser = ser_in;
        seq_par = par_in;
      end
    endcase
  end

  // ==========================================
  // four-stage register
  shift_stage4 #(
    .WIDTH(4)
  ) u_stage4 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .load(seq_load),
    .shift(seq_shift),
    .ser_in(seq_ser),
    .par_in(seq_par),
    .q(q4_w)
  );

  // ==========================================
  // eight-stage left/right register
  bidir_shift8 #(
    .WIDTH(8)
  ) u_shift8 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .dir(dir_ctl),
    .ser_right_in(ser_right_in),
    .ser_left_in(ser_left_in),
    .q(q8_w)
  );

  // ==========================================
  // end-of-period flag, aligned with the stages
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_q <= 1'b0;
    end else if (ce) begin
      end_q <= (mode_q == MODE_MODN) && is_end({seq_ser, q4_w[3:1]}) && seq_shift;
    end
  end

  // ==========================================
  // outputs straight from flip-flops
  assign q4 = q4_w;
  assign q8 = q8_w;
  assign period_end = end_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

// File: core/shift_seq_consts.svh
// constant figures for the shift register sequencer
// assumes inclusion by bare name from any core file
`ifndef SHIFT_SEQ_CONSTS_SVH
`define SHIFT_SEQ_CONSTS_SVH

// ==========================================
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MOD_START 8'h04
`define OFS_STATUS 8'h08

// ==========================================
// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 2
`define CTRL_TAP_BIT 4
`define CTRL_LOCK_BIT 5

// ==========================================
// status register fields
`define STAT_Q4_LSB 0
`define STAT_Q8_LSB 8
`define STAT_END_BIT 16

// ==========================================
// reset values and sequence words
`define RST_MODE 3'h0
`define RST_MOD_START 4'h7
`define RING_WORD 4'h8
`define END_WORD 4'hE
`define ALL_ONES 4'hF

`endif

// File: core/shift_seq_pkg.sv
// types shared by the shift register sequencer files
// assumes the constants header is compiled alongside
package shift_seq_pkg;

  // ==========================================
  // sequencer modes of the four-stage register
  typedef enum logic [2:0] {
    MODE_PIN   = 3'b000,
    MODE_RING  = 3'b001,
    MODE_TWIST = 3'b010,
    MODE_MODN  = 3'b011
  } mode_e;

  // ==========================================
  // direction codes of the eight-stage register
  typedef enum logic [1:0] {
    DIR_HOLD  = 2'b00,
    DIR_RIGHT = 2'b01,
    DIR_LEFT  = 2'b10,
    DIR_RSVD  = 2'b11
  } dir_e;

endpackage

// File: core/shift_stage4.sv
// four-stage shift register with serial and parallel entry
// assumes controls settle between falling clock edges
`timescale 1ns/1ps
module shift_stage4 #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // controls
  input wire logic load,
  input wire logic shift,
  // data entry
  input wire logic ser_in,
  input wire logic [WIDTH-1:0] par_in,
  // stage outputs, first stage in the msb
  output logic [WIDTH-1:0] q
);

  // ==========================================
  // elaboration check
  initial begin
    if (WIDTH < 2) begin
      $error("shift_stage4 needs at least two stages");
    end
  end

  // ==========================================
  // stages, falling-edge triggered
  // clear forces zero
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      if (shift) begin
        q <= {ser_in, q[WIDTH-1:1]};
      end else if (load) begin
        q <= par_in;
      end
    end
  end

endmodule

// File: tb/pin_src.sv
// surrounding logic that drives the register pins
// assumes calls come from the bench between rising edges
`timescale 1ns/1ps
module pin_src (
  // clock
  input wire logic clk,
  // four-stage pins
  output logic ctl_load,
  output logic ctl_shift,
  output logic ser_in,
  output logic [3:0] par_in,
  // eight-stage pins
  output shift_seq_pkg::dir_e dir_ctl,
  output logic ser_right_in,
  output logic ser_left_in
);
  import shift_seq_pkg::*;
  // quiet levels from time zero
  initial begin
    {ctl_load, ctl_shift, ser_in, ser_right_in, ser_left_in} = 5'h00;
    par_in = 4'h0;
    dir_ctl = DIR_HOLD;
  end
  // levels held steady
  // changed only after a rising edge, held until the next call
  task automatic set4(input logic l, input logic s, input logic si, input logic [3:0] p);
    @(posedge clk);
    ctl_load <= l;
    ctl_shift <= s;
    ser_in <= si;
    par_in <= p;
  endtask
  // direction and serial inputs of the eight stages
  task automatic set8(input dir_e d, input logic r, input logic l);
    @(posedge clk);
    dir_ctl <= d;
    ser_right_in <= r;
    ser_left_in <= l;
  endtask
endmodule

// File: tb/seq_checker_properties.sv
// port-level checker for the sequencer top
// assumes it is bound onto every sequencer instance
`timescale 1ns/1ps
module seq_checker #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // apb
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and stages
  input wire shift_seq_pkg::dir_e dir_ctl,
  input wire logic ser_right_in,
  input wire logic ser_left_in,
  input wire logic [3:0] q4,
  input wire logic [7:0] q8,
  input wire logic period_end
);
  import shift_seq_pkg::*;
  // ==========
  // stage properties, sampled on the falling edge
  property p_clear;
    @(negedge clk) disable iff (!rst_n) $rose(rst_n) |-> q4 == 4'h0 && q8 == 8'h0 && !period_end;
  endproperty
  a_clear: assert property (p_clear) else $error("stages not clear after reset");
  property p_hold8;
    @(negedge clk) disable iff (!rst_n) ce && dir_ctl[1] == dir_ctl[0] |=> $stable(q8);
  endproperty
  a_hold8: assert property (p_hold8) else $error("eight-stage moved in hold");
  property p_right8;
    @(negedge clk) disable iff (!rst_n)
      ce && dir_ctl == DIR_RIGHT |=> q8 == {$past(ser_right_in), 7'($past(q8) >> 1)};
  endproperty
  a_right8: assert property (p_right8) else $error("eight-stage right shift wrong");
  property p_left8;
    @(negedge clk) disable iff (!rst_n) ce && dir_ctl == DIR_LEFT |=> q8 == {7'($past(q8)), $past(ser_left_in)};
  endproperty
  a_left8: assert property (p_left8) else $error("eight-stage left shift wrong");
  property p_end_word;
    @(negedge clk) disable iff (!rst_n) period_end |-> q4 == 4'hE;
  endproperty
  a_end_word: assert property (p_end_word) else $error("period end off the end word");
  property p_end_prev;
    @(negedge clk) disable iff (!rst_n) period_end |-> $past(q4) == 4'hC || $past(q4) == 4'hD;
  endproperty
  a_end_prev: assert property (p_end_prev) else $error("end word not reached by feedback");
  property p_end_pulse;
    @(negedge clk) disable iff (!rst_n) period_end |=> !period_end;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("period end longer than one cycle");
  // ==========
  // bus properties, sampled on the rising edge
  property p_ready;
    @(posedge clk) disable iff (!rst_n) psel && penable && !pready && ce |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready one cycle into access");
  property p_pulse;
    @(posedge clk) disable iff (!rst_n) pready && ce |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_unmapped;
    @(posedge clk) disable iff (!rst_n) psel && penable && !pready && ce && paddr >= 8'h0C |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
endmodule

bind shift_register_sequencer seq_checker #(.ADDR_W(ADDR_W)) seq_checker_inst (.clk(clk), .rst_n(rst_n),
  .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .dir_ctl(dir_ctl), .ser_right_in(ser_right_in), .ser_left_in(ser_left_in), .q4(q4), .q8(q8),
  .period_end(period_end));

// File: tb/tb_top.sv
// self-checking bench for the shift register sequencer
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`include "shift_seq_consts.svh"
module tb_top;
  import shift_seq_pkg::*;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, rerr;
  logic ctl_load, ctl_shift, ser_in, ser_right_in, ser_left_in, period_end;
  logic [7:0] paddr, q8;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] par_in, q4;
  logic [3:0] seq_q [$];
  dir_e dir_ctl;
  int error_cnt, num_checks;
  logic [31:0] per_ctl [4] = '{32'h3, 32'h3, 32'h3, 32'h13};
  logic [3:0] per_start [4] = '{4'h0, 4'h7, 4'hC, 4'h7};
  int per_n [4] = '{4, 15, 2, 15};
  // ==========
  // clock and design
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  shift_register_sequencer shift_register_sequencer_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctl_load(ctl_load), .ctl_shift(ctl_shift), .ser_in(ser_in), .par_in(par_in),
    .dir_ctl(dir_ctl), .ser_right_in(ser_right_in), .ser_left_in(ser_left_in), .q4(q4), .q8(q8),
    .period_end(period_end));
  pin_src pin_src_inst (.clk(clk), .ctl_load(ctl_load), .ctl_shift(ctl_shift), .ser_in(ser_in),
    .par_in(par_in), .dir_ctl(dir_ctl), .ser_right_in(ser_right_in), .ser_left_in(ser_left_in));
  // ==========
  // tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rdat);
    chk("pslverr", ee, rerr);
  endtask
  task automatic step4(input logic [3:0] e);
    @(posedge clk);
    chk("q4", e, q4);
  endtask
  // park in pin mode, load a word, then switch mode
  task automatic preload(input logic [31:0] m, input logic [3:0] w);
    apb(1'b1, `OFS_CTRL, 32'h0);
    pin_src_inst.set4(1'b1, 1'b0, 1'b0, w);
    pin_src_inst.set4(1'b0, 1'b0, 1'b0, 4'h0);
    chk("q4", w, q4);
    apb(1'b1, `OFS_CTRL, m);
  endtask
  task automatic run_seq(input logic pe_on);
    foreach (seq_q[i]) begin
      step4(seq_q[i]);
      chk("period_end", pe_on && seq_q[i] == 4'hE, period_end);
    end
  endtask
  task automatic wait_end;
    do @(posedge clk); while (period_end !== 1'b1);
  endtask
  task automatic per(input logic [31:0] c, input logic [3:0] s, input int n);
    int k;
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_MOD_START, {28'h0, s});
    apb(1'b1, `OFS_CTRL, c);
    repeat (2) wait_end();
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (period_end !== 1'b1);
    chk("period", n, k);
  endtask
  task automatic d8(input dir_e d, input logic r, input logic l, input int n, input logic [7:0] e);
    pin_src_inst.set8(d, r, l);
    repeat (n) @(posedge clk);
    chk("q8", e, q8);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  // ==========
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite} = 4'h0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk("q4", 4'h0, q4);
    rd(`OFS_CTRL, `RST_MODE, 1'b0);
    rd(`OFS_MOD_START, `RST_MOD_START, 1'b0);
    rd(`OFS_STATUS, 32'h0, 1'b0);
    rd(8'h0C, 32'h0, 1'b1);
    pin_src_inst.set4(1'b1, 1'b0, 1'b0, 4'h8);
    step4(4'h8);
    pin_src_inst.set4(1'b0, 1'b0, 1'b1, 4'hF);
    step4(4'h8);
    pin_src_inst.set4(1'b0, 1'b1, 1'b1, 4'hF);
    step4(4'hC);
    step4(4'hE);
    pin_src_inst.set4(1'b1, 1'b1, 1'b0, 4'h0);
    step4(4'h7);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("q4", 4'h0, q4);
    @(posedge clk);
    rst_n <= 1'b1;
    preload(32'h1, 4'h6);
    seq_q = '{4'h3, 4'h1, 4'h8, 4'h4, 4'h2, 4'h1, 4'h8};
    run_seq(1'b0);
    preload(32'h2, 4'h4);
    seq_q = '{4'hA, 4'hD, 4'h6, 4'h3, 4'h1, 4'h0, 4'h8, 4'hC, 4'hE, 4'hF, 4'h7, 4'h3};
    run_seq(1'b0);
    apb(1'b1, `OFS_MOD_START, 32'h0);
    preload(32'h3, 4'hF);
    seq_q = '{4'h0, 4'h8, 4'hC, 4'hE, 4'h0, 4'h8, 4'hC, 4'hE};
    run_seq(1'b1);
    for (int i = 0; i < 4; i++) begin
      per(per_ctl[i], per_start[i], per_n[i]);
    end
    d8(DIR_RIGHT, 1'b1, 1'b0, 3, 8'hE0);
    // each call lets one falling edge pass under the previous direction
    d8(DIR_LEFT, 1'b0, 1'b1, 2, 8'hC3);
    d8(DIR_HOLD, 1'b1, 1'b1, 2, 8'h87);
    d8(DIR_RSVD, 1'b0, 1'b0, 2, 8'h87);
    apb(1'b1, `OFS_CTRL, 32'h23);
    do @(posedge clk); while (q4 !== 4'hE);
    repeat (3) step4(4'hE);
    rd(`OFS_CTRL, 32'h23, 1'b0);
    apb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
    rd(`OFS_STATUS, 32'h0000_870E, 1'b0);
    wrap_up();
  end
endmodule
